// File: hw/fpprc_top.sv
// port parity, read/write direction and reset sequencing control
//
// Contract
// - port-B parity error output goes low when any lane fails parity
// - words are four nine-bit lanes, top bit of each lane is parity
// - port-B check sense follows the shared parity-sense input
// - sense high means odd parity, low means even, on both ports
// - port-B mailbox read with generation forces parity error output high
// - port-A generation input high generates parity on port-A mailbox reads
// - port-B generation input high regenerates parity on all port-B reads
// - generated parity sense follows the sense input at the read
// - reset sets almost-full and mailbox flags high; others low
// - reset release captures the two offset-select inputs
// - the captured select loads one of four preset offsets
// - port-A select high means write, low means read
// - port-A outputs not driven while port-A select is high
// - port-B select high means write, low means read
// - port-B outputs not driven while port-B select is high
`timescale 1ns/1ps
module fpprc_top
    import fpprc_pkg::*;
#(
    parameter int W     = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic                  REF_CLK,
    input  wire logic                  SYS_RST,
    input  wire logic                  RESET_N,
    input  wire logic                  PORT_A_CLOCK_EN,
    input  wire logic                  PORT_B_CLOCK_EN,
    input  wire logic                  OFFSET_SELECT_0,
    input  wire logic                  OFFSET_SELECT_1,
    input  wire logic                  PARITY_ODD_SEL,
    input  wire logic                  PORT_A_PARITY_GENERATE,
    input  wire logic                  PORT_B_PARITY_GENERATE,
    input  wire logic                  PORT_A_CHIP_SELECT_N,
    input  wire logic                  PORT_A_ENABLE,
    input  wire logic                  PORT_A_WRITE_READ_SELECT,
    input  wire logic                  PORT_A_MAILBOX_SELECT,
    input  wire logic                  PORT_B_CHIP_SELECT_N,
    input  wire logic                  PORT_B_ENABLE,
    input  wire logic                  PORT_B_WRITE_READ_SELECT,
    input  wire logic                  PORT_B_MAILBOX_SELECT,
    input  wire logic [W-1:0]          PORT_A_DATA_IN,
    output logic      [W-1:0]          PORT_A_DATA_OUT,
    output logic                       PORT_A_DATA_OE,
    input  wire logic [W-1:0]          PORT_B_DATA_IN,
    output logic      [W-1:0]          PORT_B_DATA_OUT,
    output logic                       PORT_B_DATA_OE,
    input  wire logic [W-1:0]          MAIL_TO_A_DATA,
    input  wire logic [W-1:0]          MAIL_TO_B_DATA,
    input  wire logic                  SRC_VALID,
    output logic                       SRC_READY,
    input  wire logic [W-1:0]          SRC_DATA,
    output logic                       PORT_B_PARITY_ERROR_N,
    output logic                       PORT_A_WRITE_STROBE,
    output logic                       PORT_B_WRITE_STROBE,
    output logic                       PORT_A_MAILBOX_READ,
    output logic                       PORT_B_MAILBOX_READ,
    output logic                       PORT_B_FIFO_READ,
    output logic                       RESET_DONE,
    output logic                       ALMOST_FULL_N,
    output logic                       ALMOST_EMPTY_N,
    output logic                       EMPTY_N,
    output logic                       FULL_N,
    output logic                       MAILBOX_TO_B_FLAG,
    output logic                       MAILBOX_TO_A_FLAG,
    output logic      [OFFSET_W-1:0]   ALMOST_OFFSET
);
    import fpprc_pkg::*;

    if (W != LANE_W * LANES) begin : g_bad_width
        $error("word must be four nine-bit lanes");
    end
    if (DEPTH < 2) begin : g_bad_depth
        $error("fifo depth too small");
    end

    // ---------------- reset sequencing ----------------
    fpprc_rst_state_t   st_q, st_d;
    logic [CNT_W-1:0]   cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d;
    logic [OFFSET_W-1:0] off_q, off_d;
    logic               flags_rst;

    function automatic logic [OFFSET_W-1:0] offset_lookup(input logic [1:0] sel);
        case (sel)
            2'h0:    offset_lookup = OFFSET_SEL0;
            2'h1:    offset_lookup = OFFSET_SEL1;
            2'h2:    offset_lookup = OFFSET_SEL2;
            default: offset_lookup = OFFSET_SEL3;
        endcase
    endfunction : offset_lookup

    always_comb begin
        st_d    = st_q;
        cnt_a_d = cnt_a_q;
        cnt_b_d = cnt_b_q;
        off_d   = off_q;
        case (st_q)
            ST_IDLE: begin
                if (!RESET_N) begin
                    st_d    = ST_HOLD;
                    cnt_a_d = CNT_W'(PORT_A_CLOCK_EN);
                    cnt_b_d = CNT_W'(PORT_B_CLOCK_EN);
                end
            end
            ST_HOLD: begin
                // each port domain counts its own edges under reset
                if (!RESET_N) begin
                    if (PORT_A_CLOCK_EN && cnt_a_q < CNT_W'(RESET_EDGES)) begin
                        cnt_a_d = cnt_a_q + 1'b1;
                    end
                    if (PORT_B_CLOCK_EN && cnt_b_q < CNT_W'(RESET_EDGES)) begin
                        cnt_b_d = cnt_b_q + 1'b1;
                    end
                end else if (cnt_a_q >= CNT_W'(RESET_EDGES) && cnt_b_q >= CNT_W'(RESET_EDGES)) begin
                    st_d  = ST_RUN;
                    off_d = offset_lookup({OFFSET_SELECT_1, OFFSET_SELECT_0});
                end else begin
                    // too short a reset pulse: not a completed reset
                    st_d = ST_IDLE;
                end
            end
            ST_RUN: begin
                if (!RESET_N) begin
                    st_d    = ST_HOLD;
                    cnt_a_d = CNT_W'(PORT_A_CLOCK_EN);
                    cnt_b_d = CNT_W'(PORT_B_CLOCK_EN);
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            st_q    <= ST_IDLE;
            cnt_a_q <= '0;
            cnt_b_q <= '0;
            off_q   <= OFFSET_RST;
        end else begin
            st_q    <= st_d;
            cnt_a_q <= cnt_a_d;
            cnt_b_q <= cnt_b_d;
            off_q   <= off_d;
        end
    end

    assign flags_rst  = (st_q == ST_HOLD) && (cnt_a_q >= CNT_W'(RESET_EDGES))
                        && (cnt_b_q >= CNT_W'(RESET_EDGES));
    assign RESET_DONE = (st_q == ST_RUN);
    assign ALMOST_OFFSET = off_q;

    // reset flag levels; once in the run state this block drives them low
    logic flag_af_q, flag_d;
    always_comb begin
        flag_d = flag_af_q;
        if (flags_rst) begin
            flag_d = 1'b1;
        end else if (st_q == ST_RUN) begin
            flag_d = 1'b0;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            flag_af_q <= 1'b0;
        end else begin
            flag_af_q <= flag_d;
        end
    end
    assign ALMOST_FULL_N     = flag_af_q;
    assign MAILBOX_TO_B_FLAG = flag_af_q;
    assign MAILBOX_TO_A_FLAG = flag_af_q;
    assign EMPTY_N           = 1'b0;
    assign ALMOST_EMPTY_N    = 1'b0;
    assign FULL_N            = 1'b0;

    // ---------------- port operation decode ----------------
    logic a_sel, b_sel, a_mb_rd, b_mb_rd, b_fifo_rd;
    always_comb begin
        a_sel     = RESET_DONE && !PORT_A_CHIP_SELECT_N && PORT_A_ENABLE && PORT_A_CLOCK_EN;
        b_sel     = RESET_DONE && !PORT_B_CHIP_SELECT_N && PORT_B_ENABLE && PORT_B_CLOCK_EN;
        a_mb_rd   = a_sel && !PORT_A_WRITE_READ_SELECT && PORT_A_MAILBOX_SELECT;
        b_mb_rd   = b_sel && !PORT_B_WRITE_READ_SELECT && PORT_B_MAILBOX_SELECT;
        b_fifo_rd = b_sel && !PORT_B_WRITE_READ_SELECT && !PORT_B_MAILBOX_SELECT;
    end
    assign PORT_A_WRITE_STROBE = a_sel && PORT_A_WRITE_READ_SELECT;
    assign PORT_B_WRITE_STROBE = b_sel && PORT_B_WRITE_READ_SELECT;
    assign PORT_A_MAILBOX_READ = a_mb_rd;
    assign PORT_B_MAILBOX_READ = b_mb_rd;

    // ---------------- data path fifo ----------------
    fpprc_stream_if #(.W(W)) src_s ();
    fpprc_stream_if #(.W(W)) dst_s ();
    assign src_s.valid = SRC_VALID;
    assign src_s.data  = SRC_DATA;
    assign SRC_READY   = src_s.ready;
    assign dst_s.ready = b_fifo_rd;
    assign PORT_B_FIFO_READ = b_fifo_rd && dst_s.valid;

    fpprc_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
        .clk   (REF_CLK),
        .rst   (SYS_RST || !RESET_N),
        .in_s  (src_s),
        .out_s (dst_s)
    );

    // ---------------- parity ----------------
    logic [W-1:0] b_src, b_gen, a_gen;
    logic         b_ok;
    assign b_src = PORT_B_MAILBOX_SELECT ? MAIL_TO_B_DATA : dst_s.data;

    // port-B bus check always sees the bus; the shared-tree case is forced below
    fpprc_parity #(.W(W)) u_par_b (
        .data_in  (PORT_B_DATA_IN),
        .odd_sel  (PARITY_ODD_SEL),
        .lane_ok  (b_ok),
        .data_gen (b_gen)
    );
    fpprc_parity #(.W(W)) u_par_a (
        .data_in  (MAIL_TO_A_DATA),
        .odd_sel  (PARITY_ODD_SEL),
        .lane_ok  (),
        .data_gen (a_gen)
    );
    logic [W-1:0] b_gen_rd;
    fpprc_parity #(.W(W)) u_par_bo (
        .data_in  (b_src),
        .odd_sel  (PARITY_ODD_SEL),
        .lane_ok  (),
        .data_gen (b_gen_rd)
    );

    // ---------------- output registers ----------------
    logic [W-1:0] a_out_q, a_out_d, b_out_q, b_out_d;
    logic         pef_q, pef_d;
    always_comb begin
        a_out_d = a_out_q;
        b_out_d = b_out_q;
        pef_d   = b_ok;
        if (b_mb_rd && PORT_B_PARITY_GENERATE) begin
            pef_d = 1'b1;
        end
        if (a_mb_rd) begin
            a_out_d = PORT_A_PARITY_GENERATE ? a_gen : MAIL_TO_A_DATA;
        end
        if (b_mb_rd || (b_fifo_rd && dst_s.valid)) begin
            b_out_d = PORT_B_PARITY_GENERATE ? b_gen_rd : b_src;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            a_out_q <= '0;
            b_out_q <= '0;
            pef_q   <= 1'b1;
        end else begin
            a_out_q <= a_out_d;
            b_out_q <= b_out_d;
            pef_q   <= pef_d;
        end
    end
    assign PORT_B_PARITY_ERROR_N = pef_q;
    assign PORT_A_DATA_OUT = a_out_q;
    assign PORT_B_DATA_OUT = b_out_q;
    assign PORT_A_DATA_OE  = !PORT_A_WRITE_READ_SELECT;
    assign PORT_B_DATA_OE  = !PORT_B_WRITE_READ_SELECT;
    logic unused_bgen;
    // port-A bus checking lives outside this block
    assign unused_bgen = (^b_gen) ^ (^PORT_A_DATA_IN);
endmodule : fpprc_top

// File: hw/fpprc_pkg.sv
// shared constants and types for the port parity and reset control block
package fpprc_pkg;
    localparam int WORD_W       = 36;
    localparam int LANE_W       = 9;
    localparam int LANES        = 4;
    localparam int RESET_EDGES  = 4;
    localparam int FIFO_DEPTH   = 16;
    localparam int CNT_W        = 3;
    localparam int OFFSET_W     = 6;
    localparam logic [OFFSET_W-1:0] OFFSET_SEL0 = 6'h10;
    localparam logic [OFFSET_W-1:0] OFFSET_SEL1 = 6'h0C;
    localparam logic [OFFSET_W-1:0] OFFSET_SEL2 = 6'h08;
    localparam logic [OFFSET_W-1:0] OFFSET_SEL3 = 6'h04;
    localparam logic [OFFSET_W-1:0] OFFSET_RST  = 6'h10;
    typedef logic [WORD_W-1:0] fpprc_word_t;
    typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RUN} fpprc_rst_state_t;

    // parity bit of one lane's eight data bits for the selected sense
    function automatic logic lane_parity(input logic [LANE_W-2:0] data, input logic odd);
        lane_parity = (^data) ^ odd;
    endfunction : lane_parity
endpackage : fpprc_pkg

// File: hw/fpprc_stream_if.sv
// valid/ready word stream between the block's modules
`timescale 1ns/1ps
interface fpprc_stream_if #(parameter int W = 36);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fpprc_stream_if

// File: hw/fpprc_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module fpprc_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    fpprc_stream_if.snk in_s,
    fpprc_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two");
    end
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
    logic         full, empty, push, pop;

    always_comb begin
        empty = (wp_q == rp_q);
        full  = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
        push  = in_s.valid && !full;
        pop   = out_s.ready && !empty;
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
    end
    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem[rp_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_s.data;
        end
    end
endmodule : fpprc_fifo

// File: hw/fpprc_parity.sv
// four-lane parity checker and generator
`timescale 1ns/1ps
module fpprc_parity
    import fpprc_pkg::*;
#(
    parameter int W = 36
) (
    input  wire logic [W-1:0] data_in,
    input  wire logic         odd_sel,
    output logic              lane_ok,
    output logic [W-1:0]      data_gen
);
    if (W != LANE_W * LANES) begin : g_bad_width
        $error("width must be four nine-bit lanes");
    end
    logic [LANES-1:0] bad;
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        // the top bit of each lane holds the parity
        always_comb begin
            bad[i] = lane_parity(data_in[i*LANE_W +: LANE_W-1], odd_sel)
                     != data_in[i*LANE_W + LANE_W-1];
            data_gen[i*LANE_W +: LANE_W] = {lane_parity(data_in[i*LANE_W +: LANE_W-1], odd_sel),
                                            data_in[i*LANE_W +: LANE_W-1]};
        end
    end
    assign lane_ok = ~|bad;
endmodule : fpprc_parity

// File: dv/fpprc_top_checker.sv
// concurrent checks on the pins of the port parity and reset control block
`timescale 1ns/1ps
module fpprc_top_checker
    import fpprc_pkg::*;
#(
    parameter int W = WORD_W
) (
    input wire logic                REF_CLK,
    input wire logic                SYS_RST,
    input wire logic                RESET_DONE,
    input wire logic                PORT_A_WRITE_READ_SELECT,
    input wire logic                PORT_A_DATA_OE,
    input wire logic                PORT_B_WRITE_READ_SELECT,
    input wire logic                PORT_B_DATA_OE,
    input wire logic                PORT_B_CHIP_SELECT_N,
    input wire logic                PORT_B_ENABLE,
    input wire logic                PORT_B_CLOCK_EN,
    input wire logic                PORT_B_MAILBOX_SELECT,
    input wire logic                PORT_B_MAILBOX_READ,
    input wire logic                PORT_B_WRITE_STROBE,
    input wire logic                PORT_B_PARITY_GENERATE,
    input wire logic                PARITY_ODD_SEL,
    input wire logic [W-1:0]        PORT_B_DATA_IN,
    input wire logic                PORT_B_PARITY_ERROR_N,
    input wire logic                ALMOST_FULL_N,
    input wire logic                MAILBOX_TO_B_FLAG,
    input wire logic                MAILBOX_TO_A_FLAG,
    input wire logic                EMPTY_N,
    input wire logic                ALMOST_EMPTY_N,
    input wire logic                FULL_N,
    input wire logic                OFFSET_SELECT_0,
    input wire logic                OFFSET_SELECT_1,
    input wire logic [OFFSET_W-1:0] ALMOST_OFFSET
);
    localparam logic [OFFSET_W-1:0] OFFS [4] = '{OFFSET_SEL0, OFFSET_SEL1, OFFSET_SEL2, OFFSET_SEL3};
    logic b_fail;
    logic b_mrd;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    // some lane whose nine bits disagree with the selected sense
    always_comb begin
        b_fail = 1'h0;
        for (int k = 0; k < LANES; k++) begin
            b_fail = b_fail | ((^PORT_B_DATA_IN[k*LANE_W +: LANE_W]) != PARITY_ODD_SEL);
        end
    end
    assign b_mrd = RESET_DONE && !PORT_B_CHIP_SELECT_N && PORT_B_ENABLE && PORT_B_CLOCK_EN
                   && !PORT_B_WRITE_READ_SELECT && PORT_B_MAILBOX_SELECT;

    chk_a_drive_dir: assert property (PORT_A_DATA_OE == !PORT_A_WRITE_READ_SELECT)
        else $error("port A output enable wrong");
    chk_b_drive_dir: assert property (PORT_B_DATA_OE == !PORT_B_WRITE_READ_SELECT)
        else $error("port B output enable wrong");
    chk_b_read_select: assert property (b_mrd |-> PORT_B_MAILBOX_READ && !PORT_B_WRITE_STROBE)
        else $error("port B read not decoded");
    chk_pef_forced: assert property (b_mrd && PORT_B_PARITY_GENERATE |=> PORT_B_PARITY_ERROR_N)
        else $error("parity error not forced high");
    chk_pef_fail: assert property (
        RESET_DONE && b_fail && !(b_mrd && PORT_B_PARITY_GENERATE) |=> !PORT_B_PARITY_ERROR_N)
        else $error("bad lane not flagged");
    chk_pef_pass: assert property (RESET_DONE && !b_fail |=> PORT_B_PARITY_ERROR_N)
        else $error("good word flagged");
    chk_reset_flags: assert property (
        $rose(RESET_DONE) |-> ##[0:1] (ALMOST_FULL_N && MAILBOX_TO_B_FLAG && MAILBOX_TO_A_FLAG
                                       && !EMPTY_N && !ALMOST_EMPTY_N && !FULL_N))
        else $error("flag levels wrong after reset");
    chk_offset_load: assert property (
        $rose(RESET_DONE) |-> ##[0:1] (ALMOST_OFFSET == OFFS[{OFFSET_SELECT_1, OFFSET_SELECT_0}]))
        else $error("offset not loaded from selects");
endmodule : fpprc_top_checker

bind fpprc_top fpprc_top_checker #(.W(W)) u_checker (.*);

// File: dv/fpprc_src_model.sv
// word source at the fill side of the block's fifo
`timescale 1ns/1ps
module fpprc_src_model
    import fpprc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [5:0] limit,
    input  wire logic       ready,
    output logic            valid,
    output fpprc_word_t     data,
    output logic [5:0]      sent
);
    function automatic fpprc_word_t pat(input int n);
        pat = 36'h5_A000_0000 ^ {6{n[5:0]}};
    endfunction : pat

    // a word stays offered until taken; an idle bus shows the inverted last word
    assign valid = (sent < limit);
    assign data  = valid ? pat(sent) : ~pat(int'(sent) - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            sent <= 6'h00;
        end else if (valid && ready) begin
            sent <= sent + 6'h01;
        end
    end
endmodule : fpprc_src_model

// File: dv/test_fpprc_top.sv
// self-checking bench for the port parity and reset control block
`timescale 1ns/1ps
module test_fpprc_top;
    import fpprc_pkg::*;
    localparam fpprc_word_t BASE = 36'h9_5A3C_E718;
    localparam fpprc_word_t MAV  = 36'hF_0F0F_1234;
    localparam fpprc_word_t MBV  = 36'h3_C3C3_ABCD;
    logic REF_CLK, SYS_RST, RESET_N, PORT_A_CLOCK_EN, PORT_B_CLOCK_EN, OFFSET_SELECT_0;
    logic OFFSET_SELECT_1, PARITY_ODD_SEL, PORT_A_PARITY_GENERATE, PORT_B_PARITY_GENERATE;
    logic PORT_A_CHIP_SELECT_N, PORT_A_ENABLE, PORT_A_WRITE_READ_SELECT, PORT_A_MAILBOX_SELECT;
    logic PORT_B_CHIP_SELECT_N, PORT_B_ENABLE, PORT_B_WRITE_READ_SELECT, PORT_B_MAILBOX_SELECT;
    logic PORT_A_DATA_OE, PORT_B_DATA_OE, SRC_VALID, SRC_READY, PORT_B_PARITY_ERROR_N;
    logic PORT_A_WRITE_STROBE, PORT_B_WRITE_STROBE, PORT_A_MAILBOX_READ, PORT_B_MAILBOX_READ;
    logic PORT_B_FIFO_READ, RESET_DONE, ALMOST_FULL_N, ALMOST_EMPTY_N, EMPTY_N, FULL_N;
    logic MAILBOX_TO_B_FLAG, MAILBOX_TO_A_FLAG;
    logic [OFFSET_W-1:0] ALMOST_OFFSET;
    logic [OFFSET_W-1:0] offs [4];
    logic [5:0]          limit;
    logic [5:0]          sent;
    fpprc_word_t PORT_A_DATA_IN, PORT_A_DATA_OUT, PORT_B_DATA_IN, PORT_B_DATA_OUT;
    fpprc_word_t MAIL_TO_A_DATA, MAIL_TO_B_DATA, SRC_DATA, w, strb;
    int          mismatches, checked;

    fpprc_top #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) uut (.*);
    fpprc_src_model src (.clk(REF_CLK), .rst(SYS_RST), .limit(limit), .ready(SRC_READY),
                         .valid(SRC_VALID), .data(SRC_DATA), .sent(sent));

    initial begin
        REF_CLK = 1'h0;
        forever #20 REF_CLK = ~REF_CLK;
    end

    function automatic fpprc_word_t gen(input fpprc_word_t d, input logic odd);
        for (int k = 0; k < LANES; k++) begin
            gen[k*LANE_W +: LANE_W] = {(^d[k*LANE_W +: 8]) ^ odd, d[k*LANE_W +: 8]};
        end
    endfunction : gen

    task automatic print_verdict;
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic cmp(input fpprc_word_t got, input fpprc_word_t exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic give_up(input logic bad);
        if (bad) begin
            mismatches++;
            print_verdict();
        end
    endtask : give_up

    // one port cycle; strobes and enables are captured mid-cycle
    task automatic op(input logic a, input logic wr, input logic mb);
        @(posedge REF_CLK);
        if (a) begin
            {PORT_A_CHIP_SELECT_N, PORT_A_ENABLE, PORT_A_CLOCK_EN,
             PORT_A_WRITE_READ_SELECT, PORT_A_MAILBOX_SELECT} <= {3'h3, wr, mb};
        end else begin
            {PORT_B_CHIP_SELECT_N, PORT_B_ENABLE, PORT_B_CLOCK_EN,
             PORT_B_WRITE_READ_SELECT, PORT_B_MAILBOX_SELECT} <= {3'h3, wr, mb};
        end
        @(negedge REF_CLK);
        strb = fpprc_word_t'({PORT_A_WRITE_STROBE, PORT_B_WRITE_STROBE, PORT_A_MAILBOX_READ,
            PORT_B_MAILBOX_READ, PORT_B_FIFO_READ, PORT_A_DATA_OE, PORT_B_DATA_OE});
        @(posedge REF_CLK);
        {PORT_A_CHIP_SELECT_N, PORT_A_ENABLE, PORT_A_CLOCK_EN,
         PORT_A_WRITE_READ_SELECT, PORT_A_MAILBOX_SELECT} <= 5'h12;
        {PORT_B_CHIP_SELECT_N, PORT_B_ENABLE, PORT_B_CLOCK_EN,
         PORT_B_WRITE_READ_SELECT, PORT_B_MAILBOX_SELECT} <= 5'h12;
        @(negedge REF_CLK);
    endtask : op

    // hold reset low over four port-B edges and na port-A edges
    task automatic dev_reset(input int na, input logic [1:0] sel);
        @(posedge REF_CLK);
        RESET_N <= 1'h0;
        {OFFSET_SELECT_1, OFFSET_SELECT_0} <= sel;
        for (int i = 0; i < 4; i++) begin
            PORT_A_CLOCK_EN <= (i < na);
            PORT_B_CLOCK_EN <= 1'h1;
            @(posedge REF_CLK);
        end
        RESET_N <= 1'h1;
        {PORT_A_CLOCK_EN, PORT_B_CLOCK_EN} <= 2'h0;
        for (int i = 0; i < 4 && RESET_DONE !== 1'h1; i++) @(negedge REF_CLK);
    endtask : dev_reset

    initial begin
        {SYS_RST, RESET_N, PORT_A_CLOCK_EN, PORT_B_CLOCK_EN, OFFSET_SELECT_0} = 5'h18;
        {OFFSET_SELECT_1, PARITY_ODD_SEL, PORT_A_PARITY_GENERATE, PORT_B_PARITY_GENERATE} = 4'h0;
        {PORT_A_CHIP_SELECT_N, PORT_A_ENABLE, PORT_A_CLOCK_EN,
         PORT_A_WRITE_READ_SELECT, PORT_A_MAILBOX_SELECT} = 5'h12;
        {PORT_B_CHIP_SELECT_N, PORT_B_ENABLE, PORT_B_CLOCK_EN,
         PORT_B_WRITE_READ_SELECT, PORT_B_MAILBOX_SELECT} = 5'h12;
        {PORT_A_DATA_IN, PORT_B_DATA_IN, MAIL_TO_A_DATA, MAIL_TO_B_DATA} = {72'h0, MAV, MBV};
        offs = '{OFFSET_SEL0, OFFSET_SEL1, OFFSET_SEL2, OFFSET_SEL3};
        limit = 6'h00;
        mismatches = 0;
        checked = 0;
        repeat (3) @(posedge REF_CLK);
        SYS_RST <= 1'h0;
        dev_reset(3, 2'h0);
        cmp(fpprc_word_t'(RESET_DONE), 36'h0);
        for (int s = 0; s < 4; s++) begin
            dev_reset(4, s[1:0]);
            give_up(RESET_DONE !== 1'h1);
            cmp(fpprc_word_t'(ALMOST_OFFSET), fpprc_word_t'(offs[s]));
        end
        for (int i = 0; i < 10; i++) begin
            w = gen(BASE, i[0]);
            if (i < 8) w[(i / 2) * LANE_W + 2] = ~w[(i / 2) * LANE_W + 2];
            @(posedge REF_CLK);
            PARITY_ODD_SEL <= i[0];
            PORT_B_DATA_IN <= w;
            @(posedge REF_CLK);
            @(negedge REF_CLK);
            cmp(fpprc_word_t'(PORT_B_PARITY_ERROR_N), fpprc_word_t'(i >= 8));
        end
        op(1'h1, 1'h1, 1'h0);
        cmp(strb, 36'h40);
        op(1'h0, 1'h1, 1'h0);
        cmp(strb, 36'h20);
        for (int j = 0; j < 4; j++) begin
            @(posedge REF_CLK);
            {PORT_A_PARITY_GENERATE, PORT_B_PARITY_GENERATE} <= {2{j[1]}};
            PARITY_ODD_SEL <= j[0];
            PORT_B_DATA_IN <= gen(BASE, j[0]) ^ 36'h1;
            op(1'h0, 1'h0, 1'h1);
            cmp(strb, 36'h09);
            cmp(PORT_B_DATA_OUT, j[1] ? gen(MBV, j[0]) : MBV);
            cmp(fpprc_word_t'(PORT_B_PARITY_ERROR_N), fpprc_word_t'(j[1]));
            op(1'h1, 1'h0, 1'h1);
            cmp(strb, 36'h12);
            cmp(PORT_A_DATA_OUT, j[1] ? gen(MAV, j[0]) : MAV);
        end
        @(posedge REF_CLK);
        limit <= 6'h10;
        for (int i = 0; i < 40 && SRC_READY !== 1'h0; i++) @(negedge REF_CLK);
        give_up(SRC_READY !== 1'h0);
        cmp(fpprc_word_t'(sent), fpprc_word_t'(FIFO_DEPTH));
        @(posedge REF_CLK);
        limit <= 6'h11;
        repeat (4) @(negedge REF_CLK);
        cmp(fpprc_word_t'(sent), fpprc_word_t'(FIFO_DEPTH));
        for (int k = 0; k < 17; k++) begin
            op(1'h0, 1'h0, 1'h0);
            cmp(strb, 36'h05);
            cmp(PORT_B_DATA_OUT, gen(src.pat(k), 1'h1));
        end
        op(1'h0, 1'h0, 1'h0);
        cmp(PORT_B_DATA_OUT, gen(src.pat(16), 1'h1));
        print_verdict();
    end
endmodule : test_fpprc_top
